// ==== include/lasf_pkg.sv ====
/*
 Shared constants and types of the linear array serial front end:
 command codes, pixel layout, timing counts and the command carrier.
 Assumes a 10 MHz core clock; all users refer to names as lasf_pkg::name.
*/
package lasf_pkg;

    // ==================================================================
    // Clock and timing
    localparam int CORE_CLK_KHZ = 10000;
    localparam int STARTUP_US = 500;
    // Least time, so round up to whole cycles
    localparam int STARTUP_CYCLES = (STARTUP_US * CORE_CLK_KHZ + 999) / 1000;
    localparam logic [15:0] STARTUP_CNT_RESET = 16'h0000;

    // ==================================================================
    // Frame layout
    localparam int FRAME_BYTES = 3;
    localparam logic [1:0] LAST_BYTE_IDX = 2'(FRAME_BYTES - 1);
    localparam logic [2:0] LAST_BIT_IDX = 3'h7;
    localparam int TOKEN_BIT = 7;

    // ==================================================================
    // First control byte codes
    localparam logic [7:0] CMD_IDLE = 8'h00;
    localparam logic [7:0] CMD_CHIP_RESET = 8'hf0;
    localparam logic [7:0] CMD_READ_THR = 8'hd8;
    localparam logic [7:0] CMD_WRITE_THR = 8'hcc;
    localparam logic [7:0] CMD_START_INT = 8'hb8;
    localparam logic [7:0] CMD_START_INT_LONG = 8'hb4;
    localparam logic [7:0] CMD_READOUT_1 = 8'h9c;
    localparam logic [7:0] CMD_READOUT_2 = 8'h96;
    localparam logic [7:0] CMD_READOUT_4 = 8'h93;
    localparam logic [7:0] CMD_READOUT_8 = 8'h99;
    localparam logic [7:0] CMD_ZEBRA_1 = 8'he8;
    localparam logic [7:0] CMD_ZEBRA_2 = 8'he4;
    localparam logic [7:0] CMD_ZEBRA_12 = 8'he2;
    localparam logic [7:0] CMD_ZEBRA_0 = 8'he1;
    localparam logic [7:0] CMD_SLEEP = 8'hc6;
    localparam logic [7:0] CMD_WAKE = 8'hc3;

    // ==================================================================
    // Sanity byte and counters
    localparam logic [4:0] CMD_CNT_RESET = 5'h00;
    localparam logic [4:0] CMD_CNT_MAX = 5'h1f;
    localparam logic [4:0] CMD_CNT_WRAP = 5'h10;
    localparam logic [7:0] TX_IDLE_BYTE = 8'h00;

    // ==================================================================
    // Pixel layout: one test pixel, 142 active, one dark pixel
    localparam int ACTIVE_PIXELS = 142;
    localparam logic [7:0] PIXEL_TEST_IDX = 8'h01;
    localparam logic [7:0] PIXEL_DARK_IDX = 8'(ACTIVE_PIXELS + 2);
    localparam logic [7:0] PIXEL_IDX_RESET = 8'h00;

    // ==================================================================
    // Pin synchroniser: sclk, select, mosi idle levels
    localparam logic [2:0] SYNC_RESET = 3'h6;

    // ==================================================================
    // Command buffer
    localparam int CMD_FIFO_DEPTH = 32;

    typedef struct packed {
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] ctrl3;
    } lasf_cmd_t;

endpackage

// ==== hw/lasf_sync.sv ====
/*
 Three-stage pin synchroniser with agreement filter.
 Assumes asynchronous inputs; output changes only when stages two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none

module lasf_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Pins and filtered levels
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    // ==================================================================
    // Stages
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
        end else begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Per bit: a change counts once two and three agree
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            level_o <= RESET_VAL;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    level_o[i] <= stage3[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

// ==== hw/lasf_fifo.sv ====
/*
 Flip-flop FIFO with valid/ready on both sides.
 Assumes DEPTH is a power of two; reads are first-word fall-through.
*/
`timescale 1ns/1ps
`default_nettype none

module lasf_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);

    // ==================================================================
    // Storage and pointers
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            if (push && !pop) begin
                count <= count + (AW+1)'(1);
            end else if (pop && !push) begin
                count <= count - (AW+1)'(1);
            end
        end
    end

endmodule

`default_nettype wire

// ==== hw/lasf_frontend.sv ====
/*
 Serial slave front end of a linear optical sensor array: bit and byte
 framing, command token check, sanity byte, output shifting and pixel
 sequencing for read-out, with received commands buffered for the core.
 Assumes the pins are asynchronous to core_clk_i and the serial clock is
 well below a quarter of the core clock, so edges are found by sampling.
*/
`timescale 1ns/1ps
`default_nettype none

module lasf_frontend #(
    parameter int STARTUP_CYCLES = lasf_pkg::STARTUP_CYCLES
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // Command stream to the core
    output logic cmd_valid_o,
    output lasf_pkg::lasf_cmd_t cmd_o,
    input wire logic cmd_ready_i,
    // Pixel source
    input wire logic [7:0] pixel_data_i,
    output logic pixel_take_o,
    output logic [7:0] pixel_index_o,
    output logic pixel_is_test_o,
    output logic pixel_is_dark_o,
    // Integration control
    output logic integ_start_o,
    output logic integ_long_o,
    input wire logic integ_done_i,
    output logic zebra_inject_o,
    // Status
    output logic startup_done_o,
    output logic init_done_o,
    output logic readout_active_o,
    output logic sleep_o,
    output logic overrun_o,
    output logic chip_reset_o
);

    // ==================================================================
    // Functions
    function automatic logic is_known(input logic [7:0] code);
        case (code)
            lasf_pkg::CMD_CHIP_RESET,
            lasf_pkg::CMD_READ_THR,
            lasf_pkg::CMD_WRITE_THR,
            lasf_pkg::CMD_START_INT,
            lasf_pkg::CMD_START_INT_LONG,
            lasf_pkg::CMD_READOUT_1,
            lasf_pkg::CMD_READOUT_2,
            lasf_pkg::CMD_READOUT_4,
            lasf_pkg::CMD_READOUT_8,
            lasf_pkg::CMD_ZEBRA_1,
            lasf_pkg::CMD_ZEBRA_2,
            lasf_pkg::CMD_ZEBRA_12,
            lasf_pkg::CMD_ZEBRA_0,
            lasf_pkg::CMD_SLEEP,
            lasf_pkg::CMD_WAKE: is_known = 1'b1;
            default: is_known = 1'b0;
        endcase
    endfunction

    function automatic logic is_readout(input logic [7:0] code);
        is_readout = (code == lasf_pkg::CMD_READOUT_1) || (code == lasf_pkg::CMD_READOUT_2) ||
                     (code == lasf_pkg::CMD_READOUT_4) || (code == lasf_pkg::CMD_READOUT_8);
    endfunction

    // ==================================================================
    // Pin sampling and edge finding
    logic [2:0] pins;
    logic [2:0] levels;
    logic sclk_f;
    logic cs_n_f;
    logic mosi_f;
    logic sclk_q;
    logic sel;
    logic rise;
    logic fall;

    assign pins = {sclk_i, cs_n_i, mosi_i};

    lasf_sync #(
        .WIDTH(3),
        .RESET_VAL(lasf_pkg::SYNC_RESET)
    ) u_sync (
        .clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .pin_i(pins),
        .level_o(levels)
    );

    assign sclk_f = levels[2];
    assign cs_n_f = levels[1];
    assign mosi_f = levels[0];

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            sclk_q <= 1'b1;
        end else begin
            sclk_q <= sclk_f;
        end
    end

    // Edges only count while selected
    assign sel = !cs_n_f;
    assign rise = sel && sclk_f && !sclk_q;
    assign fall = sel && !sclk_f && sclk_q;

    // ==================================================================
    // Bit synchronisation counter
    logic [2:0] bit_cnt;
    logic [1:0] byte_idx;
    logic byte_done;
    logic frame_done;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i || !sel) begin
            // Deselect clears the count so the next command starts afresh
            bit_cnt <= 3'h0;
            byte_idx <= 2'h0;
        end else if (rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == lasf_pkg::LAST_BIT_IDX) begin
                byte_idx <= (byte_idx == lasf_pkg::LAST_BYTE_IDX) ? 2'h0 : byte_idx + 2'h1;
            end
        end
    end

    assign byte_done = rise && (bit_cnt == lasf_pkg::LAST_BIT_IDX);
    assign frame_done = byte_done && (byte_idx == lasf_pkg::LAST_BYTE_IDX);

    // ==================================================================
    // Receive shifter and frame assembly
    logic [7:0] rx_shift;
    logic [7:0] rx_byte;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    lasf_pkg::lasf_cmd_t frame;
    logic token;
    logic known;
    logic accept;
    logic is_cr;

    assign rx_byte = {rx_shift[6:0], mosi_f};

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            rx_shift <= 8'h00;
            ctrl1 <= 8'h00;
            ctrl2 <= 8'h00;
        end else if (rise) begin
            rx_shift <= rx_byte;
            if (byte_done && byte_idx == 2'h0) begin
                ctrl1 <= rx_byte;
            end
            if (byte_done && byte_idx == 2'h1) begin
                ctrl2 <= rx_byte;
            end
        end
    end

    assign frame = '{ctrl1: ctrl1, ctrl2: ctrl2, ctrl3: rx_byte};
    assign token = ctrl1[lasf_pkg::TOKEN_BIT];
    assign known = token && is_known(ctrl1);
    assign accept = frame_done && known;
    assign is_cr = accept && (ctrl1 == lasf_pkg::CMD_CHIP_RESET);

    // ==================================================================
    // Command buffer toward the core
    logic fifo_in_ready;
    logic [23:0] fifo_out;

    // A full buffer cannot stall the master, so the frame is dropped and flagged
    lasf_fifo #(
        .WIDTH(24),
        .DEPTH(lasf_pkg::CMD_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(accept),
        .in_ready_o(fifo_in_ready),
        .in_data_i(frame),
        .out_valid_o(cmd_valid_o),
        .out_ready_i(cmd_ready_i),
        .out_data_o(fifo_out)
    );

    assign cmd_o = fifo_out;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            overrun_o <= 1'b0;
        end else begin
            if (is_cr) begin
                overrun_o <= 1'b0;
            end
            // Set after clear so a drop in the same cycle stays visible
            if (accept && !fifo_in_ready) begin
                overrun_o <= 1'b1;
            end
        end
    end

    // ==================================================================
    // Start-up timer, restarted on wake
    logic [15:0] startup_cnt;
    logic wake;

    assign wake = accept && sleep_o && (ctrl1 == lasf_pkg::CMD_WAKE || ctrl1 == lasf_pkg::CMD_CHIP_RESET);

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i || wake) begin
            startup_cnt <= lasf_pkg::STARTUP_CNT_RESET;
            startup_done_o <= 1'b0;
        end else if (startup_cnt == 16'(STARTUP_CYCLES)) begin
            startup_done_o <= 1'b1;
        end else begin
            startup_cnt <= startup_cnt + 16'h0001;
        end
    end

    // ==================================================================
    // Device state: init, sleep, command counter
    logic [4:0] cmd_cnt;
    logic [7:0] sanity;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            init_done_o <= 1'b0;
            sleep_o <= 1'b0;
            cmd_cnt <= lasf_pkg::CMD_CNT_RESET;
            chip_reset_o <= 1'b0;
        end else begin
            chip_reset_o <= is_cr;
            if (is_cr) begin
                // Initialisation completes only with the master's chip reset
                init_done_o <= 1'b1;
                sleep_o <= 1'b0;
                cmd_cnt <= lasf_pkg::CMD_CNT_RESET;
            end else if (accept) begin
                cmd_cnt <= (cmd_cnt == lasf_pkg::CMD_CNT_MAX) ? lasf_pkg::CMD_CNT_WRAP : cmd_cnt + 5'h01;
                if (ctrl1 == lasf_pkg::CMD_SLEEP) begin
                    sleep_o <= 1'b1;
                end else if (ctrl1 == lasf_pkg::CMD_WAKE) begin
                    sleep_o <= 1'b0;
                end
            end
        end
    end

    assign sanity = {!sleep_o, init_done_o, 1'b1, cmd_cnt};

    // ==================================================================
    // Integration and test pixel pattern
    logic integrating;
    logic si_cmd;

    assign si_cmd = accept && (ctrl1 == lasf_pkg::CMD_START_INT || ctrl1 == lasf_pkg::CMD_START_INT_LONG);

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            integrating <= 1'b0;
            integ_start_o <= 1'b0;
            integ_long_o <= 1'b0;
        end else begin
            integ_start_o <= 1'b0;
            if (is_cr || integ_done_i) begin
                integrating <= 1'b0;
            end
            // Integration is refused until references are stable
            if (si_cmd && startup_done_o && !sleep_o) begin
                integrating <= 1'b1;
                integ_start_o <= 1'b1;
                integ_long_o <= (ctrl1 == lasf_pkg::CMD_START_INT_LONG);
            end
        end
    end

    // Zebra on pixel 1 for the whole integration cycle
    assign zebra_inject_o = integrating;

    // ==================================================================
    // Read-out pixel sequencing
    logic tx_load;
    logic take;

    assign tx_load = fall && (bit_cnt == 3'h0);
    assign take = tx_load && readout_active_o;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            readout_active_o <= 1'b0;
            pixel_index_o <= lasf_pkg::PIXEL_IDX_RESET;
            pixel_take_o <= 1'b0;
        end else begin
            pixel_take_o <= take;
            if (is_cr) begin
                readout_active_o <= 1'b0;
                pixel_index_o <= lasf_pkg::PIXEL_IDX_RESET;
            end else if (accept && is_readout(ctrl1)) begin
                readout_active_o <= 1'b1;
                pixel_index_o <= lasf_pkg::PIXEL_TEST_IDX;
            end else if (take) begin
                // Dark pixel is the last one, sent like any other
                if (pixel_index_o == lasf_pkg::PIXEL_DARK_IDX) begin
                    readout_active_o <= 1'b0;
                end else begin
                    pixel_index_o <= pixel_index_o + 8'h01;
                end
            end
        end
    end

    assign pixel_is_test_o = readout_active_o && (pixel_index_o == lasf_pkg::PIXEL_TEST_IDX);
    assign pixel_is_dark_o = readout_active_o && (pixel_index_o == lasf_pkg::PIXEL_DARK_IDX);

    // ==================================================================
    // Transmit shifter
    logic [7:0] tx_shift;
    logic [7:0] tx_next;

    always_comb begin
        if (readout_active_o) begin
            tx_next = pixel_data_i;
        end else if (byte_idx == 2'h0) begin
            tx_next = sanity;
        end else begin
            tx_next = lasf_pkg::TX_IDLE_BYTE;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i || !sel) begin
            tx_shift <= lasf_pkg::TX_IDLE_BYTE;
        end else if (tx_load) begin
            tx_shift <= tx_next;
        end else if (fall) begin
            tx_shift <= {tx_shift[6:0], 1'b0};
        end
    end

    assign miso_o = tx_shift[7];
    // Enable follows select only; reset also releases the line
    assign miso_oe_o = sel;

endmodule

`default_nettype wire

// ==== tb/lasf_monitor.sv ====
/* Port checker for the serial front end, bound to lasf_frontend.
 Assumes one core clock domain and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module lasf_monitor #(
    parameter int STARTUP_CYCLES = 20
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic miso_o,
    input wire logic miso_oe_o,
    // Core side
    input wire logic cmd_valid_o,
    input wire logic [7:0] pixel_index_o,
    input wire logic pixel_is_test_o,
    input wire logic pixel_is_dark_o,
    input wire logic integ_start_o,
    input wire logic zebra_inject_o,
    input wire logic startup_done_o,
    input wire logic init_done_o,
    input wire logic readout_active_o,
    input wire logic sleep_o,
    input wire logic chip_reset_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // ==========
    // Helpers: pin sync needs time after reset
    logic [3:0] up;
    logic [3:0] hi_cnt;
    logic [15:0] lowc;
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) up <= 4'h0;
        else if (up != 4'hf) up <= up + 4'h1;
    end
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i || !sclk_i) hi_cnt <= 4'h0;
        else if (hi_cnt != 4'hf) hi_cnt <= hi_cnt + 4'h1;
    end
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i || startup_done_o) lowc <= 16'h0000;
        else lowc <= lowc + 16'h0001;
    end
    // ==========
    // Assertions
    sel_drive_a: assert property ((up == 4'hf && !cs_n_i)[*6] |-> miso_oe_o)
        else $error("output not driven while selected");
    sel_release_a: assert property ((up == 4'hf && cs_n_i)[*6] |-> !miso_oe_o && !miso_o)
        else $error("output not released while deselected");
    miso_fall_a: assert property ($changed(miso_o) && miso_oe_o && $past(miso_oe_o) |-> hi_cnt < 4'h4)
        else $error("output bit changed away from a falling edge");
    test_flag_a: assert property (pixel_is_test_o == (readout_active_o && pixel_index_o == 8'h01))
        else $error("test pixel flag wrong");
    dark_flag_a: assert property (pixel_is_dark_o == (readout_active_o && pixel_index_o == 8'h90))
        else $error("dark pixel flag wrong");
    index_range_a: assert property (readout_active_o |-> pixel_index_o >= 8'h01 && pixel_index_o <= 8'h90)
        else $error("pixel index out of range");
    zebra_on_a: assert property (integ_start_o |-> ##[0:1] zebra_inject_o)
        else $error("no test pattern during integration");
    integ_gate_a: assert property (integ_start_o |-> startup_done_o && !sleep_o)
        else $error("integration before start-up");
    startup_len_a: assert property ($rose(startup_done_o) |-> lowc >= 16'(STARTUP_CYCLES - 2))
        else $error("start-up too short");
    deselect_quiet_a: assert property ((up == 4'hf && cs_n_i)[*8] |-> !$rose(cmd_valid_o) && !chip_reset_o)
        else $error("activity while deselected");
    cr_init_a: assert property (chip_reset_o |=> init_done_o && !sleep_o)
        else $error("chip reset did not initialise");
    cover property (chip_reset_o);
    cover property (pixel_is_dark_o);
    cover property (integ_start_o);
endmodule
bind lasf_frontend lasf_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES)) lasf_monitor_i (.core_clk_i, .nrst_i,
    .sclk_i, .cs_n_i, .miso_o, .miso_oe_o, .cmd_valid_o, .pixel_index_o, .pixel_is_test_o, .pixel_is_dark_o,
    .integ_start_o, .zebra_inject_o, .startup_done_o, .init_done_o, .readout_active_o, .sleep_o, .chip_reset_o);
`default_nettype wire

// ==== tb/lasf_master.sv ====
/* Serial master model driving the front end pins.
 Assumes 1 ns time units; link clock period 800 ns. */
`timescale 1ns/1ps
`default_nettype none
module lasf_master (
    // Serial lines
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i,
    input wire logic miso_oe_i
);
    logic last = 1'b0;
    // ==========
    // Idle levels
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // ==========
    // Sends nb bits MSB first; sel low clocks with select high
    task automatic xfer(input logic [23:0] tx, input int nb, input logic sel, output logic [23:0] rx);
        rx = 24'h0;
        cs_n_o = ~sel;
        #437;
        for (int i = 23; i > 23 - nb; i--) begin
            sclk_o = 1'b0;
            mosi_o = tx[i];
            #400;
            sclk_o = 1'b1;
            #390;
            // Sample late: the answer lags the pin by several core cycles
            last = miso_oe_i ? miso_i : ~last;
            rx[i] = last;
            #10;
        end
        mosi_o = 1'b0;
        #400;
        cs_n_o = 1'b1;
        #800;
    endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
/* Testbench of the serial front end with a master model.
 Assumes the package is compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic sclk, cs_n, mosi, miso, miso_oe, cmd_valid, startup_done, init_done, ro_active, overrun, zebra;
    logic ilong, ptake;
    logic cmd_ready = 1'b0;
    logic integ_done = 1'b0;
    logic [7:0] pix_data = 8'h00;
    logic [7:0] pix_idx;
    logic [2:0] zq = 3'h0;
    logic [23:0] rx;
    lasf_pkg::lasf_cmd_t cmd;
    int num_errors = 0;
    int n_checks = 0;
    int n_take = 0;
    localparam logic [7:0] CODES [10] = '{lasf_pkg::CMD_READ_THR, lasf_pkg::CMD_WRITE_THR,
        lasf_pkg::CMD_START_INT, lasf_pkg::CMD_START_INT_LONG, lasf_pkg::CMD_ZEBRA_1, lasf_pkg::CMD_ZEBRA_2,
        lasf_pkg::CMD_ZEBRA_12, lasf_pkg::CMD_ZEBRA_0, lasf_pkg::CMD_SLEEP, lasf_pkg::CMD_WAKE};
    localparam logic [23:0] CR = {lasf_pkg::CMD_CHIP_RESET, 16'h0000};
    localparam logic [7:0] ROS [3] = '{lasf_pkg::CMD_READOUT_1, lasf_pkg::CMD_READOUT_2, lasf_pkg::CMD_READOUT_4};
    // ==========
    // Design, master, core side
    lasf_frontend #(.STARTUP_CYCLES(20)) lasf_frontend_i (.core_clk_i(core_clk), .nrst_i(nrst), .sclk_i(sclk),
        .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
        .cmd_ready_i(cmd_ready), .pixel_data_i(pix_data), .pixel_take_o(ptake), .pixel_index_o(pix_idx),
        .pixel_is_test_o(), .pixel_is_dark_o(), .integ_start_o(), .integ_long_o(ilong), .integ_done_i(integ_done),
        .zebra_inject_o(zebra), .startup_done_o(startup_done), .init_done_o(init_done),
        .readout_active_o(ro_active), .sleep_o(), .overrun_o(overrun), .chip_reset_o());
    lasf_master lasf_master_i (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));
    always #50 core_clk = ~core_clk;
    always @(negedge core_clk) begin
        zq <= {zq[1:0], zebra};
        integ_done <= zq[2];
        pix_data <= pix_idx ^ 8'h3c;
        n_take <= n_take + int'(ptake === 1'b1);
    end
    // ==========
    // Shared tasks
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic pop(input logic [23:0] exp);
        cmp(cmd_valid, 24'h1, "command valid");
        cmp(cmd, exp, "command word");
        @(negedge core_clk) cmd_ready <= 1'b1;
        @(negedge core_clk) cmd_ready <= 1'b0;
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ==========
    // Scenarios
    task automatic t_startup();
        cmp(startup_done, 24'h0, "start-up early");
        cmp(miso_oe, 24'h0, "idle drive");
        repeat (24) @(negedge core_clk);
        cmp(startup_done, 24'h1, "start-up late");
    endtask
    task automatic t_first();
        lasf_master_i.xfer(24'h000000, 24, 1'b1, rx);
        cmp(rx, 24'ha00000, "power-on sanity");
        cmp(cmd_valid, 24'h0, "idle buffered");
        lasf_master_i.xfer(CR, 24, 1'b1, rx);
        cmp(init_done, 24'h1, "init after reset");
        pop(CR);
    endtask
    task automatic t_counter();
        logic sl;
        sl = 1'b0;
        for (int j = 0; j < 33; j++) begin
            lasf_master_i.xfer({CODES[j % 10], 8'(j), ~8'(j)}, 24, 1'b1, rx);
            cmp(rx, {~sl, 2'b11, (j > 31) ? 5'h10 : 5'(j), 16'h0}, "sanity byte");
            if (j % 10 == 2 || j % 10 == 3) cmp(ilong, 24'(j % 10 == 3), "long start");
            if (CODES[j % 10] == lasf_pkg::CMD_SLEEP) sl = 1'b1;
            if (CODES[j % 10] == lasf_pkg::CMD_WAKE) sl = 1'b0;
        end
        cmp(overrun, 24'h1, "overrun when full");
        // Full buffer drops the last frame, so 32 come out
        for (int j = 0; j < 32; j++) pop({CODES[j % 10], 8'(j), ~8'(j)});
        cmp(cmd_valid, 24'h0, "buffer empty");
    endtask
    task automatic t_abort();
        foreach (ROS[m]) begin
            lasf_master_i.xfer({ROS[m], 16'h0190}, 24, 1'b1, rx);
            pop({ROS[m], 16'h0190});
            cmp(ro_active, 24'h1, "read-out mode");
        end
        lasf_master_i.xfer(CR, 24, 1'b1, rx);
        pop(CR);
        cmp(ro_active, 24'h0, "read-out cut by reset");
        cmp(overrun, 24'h0, "overrun cleared");
        lasf_master_i.xfer(24'hccffff, 12, 1'b1, rx);
        lasf_master_i.xfer(24'hccffff, 24, 1'b0, rx);
        lasf_master_i.xfer(24'hcc5a00, 24, 1'b1, rx);
        cmp(rx, 24'he00000, "count after abort");
        pop(24'hcc5a00);
    endtask
    task automatic t_readout();
        int t0;
        t0 = n_take;
        lasf_master_i.xfer({lasf_pkg::CMD_READOUT_8, 16'h0190}, 24, 1'b1, rx);
        pop({lasf_pkg::CMD_READOUT_8, 16'h0190});
        cmp(ro_active, 24'h1, "read-out started");
        for (int k = 0; k < 48; k++) begin
            lasf_master_i.xfer(24'h000000, 24, 1'b1, rx);
            for (int b = 0; b < 3; b++) cmp(rx[23 - 8 * b -: 8], 8'(3 * k + b + 1) ^ 8'h3c, "pixel");
        end
        cmp(ro_active, 24'h0, "read-out ended");
        cmp(24'(n_take - t0), 24'h90, "pixels taken");
        lasf_master_i.xfer(24'h000000, 24, 1'b1, rx);
        cmp(rx, 24'he20000, "sanity after read-out");
    endtask
    // ==========
    // Sequence and watchdog
    initial begin
        repeat (10) @(posedge core_clk);
        @(negedge core_clk) nrst <= 1'b1;
        @(negedge core_clk);
        t_startup();
        t_first();
        t_counter();
        t_abort();
        t_readout();
        end_of_test();
    end
    initial begin
        #6000000;
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
